// file: spms_top.sv
`timescale 1ns/1ps
`include "spms_cfg.svh"

module spms_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        uart_baud_overflow,
  input  wire logic        timer0_overflow,
  input  wire logic        slave_select_pin_n,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe
);

  logic [7:0]             serial_control_reg;
  logic                   rate_select_high;
  logic                   ss_gpio_out;
  logic                   transfer_done_flag;
  logic                   write_collision_flag;
  logic                   mode_fault_flag;
  logic                   holding_full_flag;
  logic [7:0]             tx_holding_reg;
  logic [7:0]             out_shift_reg;
  logic                   osr_full;
  logic [7:0]             rx_buf;
  logic [2:0]             bit_cnt;
  logic                   pending;
  logic                   in_bit;
  logic                   sck_prev;
  logic [5:0]             div_cnt;
  spms_pkg::spms_state_t  state;

  logic       en, select_ignore_bit, order, master_select_bit, clock_polarity_bit, clock_phase_bit;
  logic [2:0] rate;
  logic       wr_ev, rd_ev, data_wr, fault, master_role, ss_low;
  logic       src_tick, half_tick, edge_ev, lead, sample_ev, shift_ev;
  logic       xfer_end, active, load_osr, start;
  logic       serial_in, engine_busy_flag;
  logic [7:0] status_val;
  logic [7:0] next_osr;

  function automatic logic [5:0] half_count(input logic [2:0] code);
    case (code)
      3'h0:    half_count = `SPMS_HALF_DIV4;
      3'h1:    half_count = `SPMS_HALF_DIV8;
      3'h2:    half_count = `SPMS_HALF_DIV16;
      3'h3:    half_count = `SPMS_HALF_DIV32;
      3'h4:    half_count = `SPMS_HALF_DIV64;
      3'h5:    half_count = `SPMS_HALF_DIV2;
      default: half_count = `SPMS_HALF_OVF6;
    endcase
  endfunction

  function automatic logic [7:0] shift_byte(input logic [7:0] sr, input logic lsb_first,
                                            input logic b);
    shift_byte = lsb_first ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  function automatic logic out_bit(input logic [7:0] sr, input logic lsb_first);
    out_bit = lsb_first ? sr[0] : sr[7];
  endfunction

  assign en    = serial_control_reg[`SPMS_C_ENABLE];
  assign select_ignore_bit  = serial_control_reg[`SPMS_C_IGNORE];
  assign order = serial_control_reg[`SPMS_C_ORDER];
  assign master_select_bit  = serial_control_reg[`SPMS_C_MASTER];
  assign clock_polarity_bit  = serial_control_reg[`SPMS_C_CLOCK_POLARITY_BIT];
  assign clock_phase_bit  = serial_control_reg[`SPMS_C_CLOCK_PHASE_BIT];
  assign rate  = {rate_select_high, serial_control_reg[`SPMS_C_RATE_MID],
                  serial_control_reg[`SPMS_C_RATE_LOW]};

  // Write lands at the edge where the master sees pready
  assign wr_ev   = psel & penable & pready & pwrite;
  assign rd_ev   = psel & penable & ~pready;
  assign data_wr = wr_ev & (paddr == `SPMS_DATA_ADDR);

  assign master_role = en & master_select_bit;
  assign ss_low      = en & ~select_ignore_bit & ~slave_select_pin_n;
  assign fault       = master_role & ss_low & ~ss_gpio_out;

  // Rate source and half-period divider
  always_comb begin
    case (rate)
      `SPMS_RATE_UART:  src_tick = uart_baud_overflow;
      `SPMS_RATE_TIMER: src_tick = timer0_overflow;
      default:          src_tick = 1'b1;
    endcase
  end
  assign half_tick = (state == spms_pkg::SPMS_XFER) & src_tick &
                     (div_cnt == half_count(rate) - 6'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 6'h00;
    end else if (state != spms_pkg::SPMS_XFER || half_tick) begin
      div_cnt <= 6'h00;
    end else if (src_tick) begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // Edge events, shared by master and slave
  always_comb begin
    serial_in = master_role ? miso_in : mosi_in;
    if (master_role) begin
      edge_ev = half_tick;
      lead    = (sck_out == clock_polarity_bit);
    end else begin
      edge_ev = en & (select_ignore_bit | ss_low) & (sck_in != sck_prev);
      lead    = (sck_in != clock_polarity_bit);
    end
  end
  assign sample_ev = edge_ev & (lead ^ clock_phase_bit);
  assign shift_ev  = edge_ev & ~(lead ^ clock_phase_bit);
  assign xfer_end  = (sample_ev & clock_phase_bit & (bit_cnt == `SPMS_LAST_BIT)) |
                     (shift_ev & pending & ~clock_phase_bit & (bit_cnt == `SPMS_LAST_BIT));
  assign active    = (state == spms_pkg::SPMS_XFER) | (bit_cnt != 3'h0) | pending;
  assign load_osr  = holding_full_flag & ~osr_full & ~active;
  assign start     = master_role & osr_full & ~active & ~fault;
  assign engine_busy_flag = active | osr_full | holding_full_flag;
  // Data pins follow the shifter at the edge that shifts it, so a one-cycle half bit holds
  assign next_osr = (shift_ev && pending && !xfer_end) ?
                    shift_byte(out_shift_reg, order, in_bit) : out_shift_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= spms_pkg::SPMS_IDLE;
    end else if (fault || !master_role) begin
      state <= spms_pkg::SPMS_IDLE;
    end else if (state == spms_pkg::SPMS_IDLE) begin
      if (start) begin
        state <= spms_pkg::SPMS_XFER;
      end
    end else if (xfer_end) begin
      state <= spms_pkg::SPMS_IDLE;
    end
  end

  // Serial clock generator, stopped at idle level between bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_out <= 1'b0;
    end else if (state != spms_pkg::SPMS_XFER || xfer_end) begin
      sck_out <= clock_polarity_bit;
    end else if (half_tick) begin
      sck_out <= ~sck_out;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_in;
    end
  end

  // Circular shifter: bit out and bit in on the same byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_shift_reg <= 8'h00;
      bit_cnt       <= 3'h0;
      pending       <= 1'b0;
      in_bit        <= 1'b0;
      rx_buf        <= 8'h00;
    end else if (load_osr) begin
      out_shift_reg <= tx_holding_reg;
    end else if (fault || !en || (!master_role && !select_ignore_bit && !ss_low)) begin
      bit_cnt <= 3'h0;
      pending <= 1'b0;
    end else if (xfer_end) begin
      out_shift_reg <= shift_byte(out_shift_reg, order,
                                  clock_phase_bit ? serial_in : in_bit);
      rx_buf        <= shift_byte(out_shift_reg, order, clock_phase_bit ? serial_in : in_bit);
      bit_cnt       <= 3'h0;
      pending       <= 1'b0;
    end else if (sample_ev) begin
      in_bit  <= serial_in;
      pending <= 1'b1;
    end else if (shift_ev && pending) begin
      out_shift_reg <= shift_byte(out_shift_reg, order, in_bit);
      bit_cnt       <= bit_cnt + 3'h1;
      pending       <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osr_full <= 1'b0;
    end else if (load_osr) begin
      osr_full <= 1'b1;
    end else if (xfer_end) begin
      osr_full <= 1'b0;
    end
  end

  // Holding register and its flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_reg    <= 8'h00;
      holding_full_flag <= 1'b0;
    end else if (data_wr && !holding_full_flag) begin
      tx_holding_reg    <= pwdata[7:0];
      holding_full_flag <= 1'b1;
    end else if (load_osr) begin
      holding_full_flag <= 1'b0;
    end
  end

  // Sticky flags: a hardware set wins over a one-written clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_done_flag   <= 1'b0;
      write_collision_flag <= 1'b0;
      mode_fault_flag      <= 1'b0;
    end else begin
      transfer_done_flag <= xfer_end | fault | (transfer_done_flag &
        ~(wr_ev && paddr == `SPMS_STATUS_ADDR && pwdata[`SPMS_S_DONE]));
      write_collision_flag <= (data_wr & holding_full_flag) | (write_collision_flag &
        ~(wr_ev && paddr == `SPMS_STATUS_ADDR && pwdata[`SPMS_S_WRITE_COLLISION_FLAG]));
      mode_fault_flag <= fault | (mode_fault_flag &
        ~(wr_ev && paddr == `SPMS_STATUS_ADDR && pwdata[`SPMS_S_MODE_FAULT_FLAG]));
    end
  end

  // Control registers; a mode fault overrides software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_reg <= `SPMS_CTRL_RST;
      rate_select_high   <= 1'b0;
      ss_gpio_out        <= 1'b0;
    end else begin
      if (fault) begin
        serial_control_reg[`SPMS_C_MASTER] <= 1'b0;
        serial_control_reg[`SPMS_C_ENABLE] <= 1'b0;
      end else if (wr_ev && paddr == `SPMS_CTRL_ADDR) begin
        serial_control_reg <= pwdata[7:0];
      end
      if (wr_ev && paddr == `SPMS_STATUS_ADDR) begin
        rate_select_high <= pwdata[`SPMS_S_RATE_HIGH];
      end
      if (wr_ev && paddr == `SPMS_PINCFG_ADDR) begin
        ss_gpio_out <= pwdata[`SPMS_P_SS_GPIO];
      end
    end
  end

  // Pin directions, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mosi_oe  <= 1'b0;
      miso_oe  <= 1'b0;
      sck_oe   <= 1'b0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
    end else begin
      mosi_oe  <= master_role & ~fault & (select_ignore_bit | active | start);
      sck_oe   <= master_role & ~fault & (select_ignore_bit | active | start);
      miso_oe  <= en & (~master_select_bit | fault) & (select_ignore_bit | ss_low);
      mosi_out <= out_bit(next_osr, order);
      miso_out <= out_bit(next_osr, order);
    end
  end

  // APB slave: one wait state, error on unmapped address
  always_comb begin
    status_val = 8'h00;
    status_val[`SPMS_S_DONE]      = transfer_done_flag;
    status_val[`SPMS_S_WRITE_COLLISION_FLAG]      = write_collision_flag;
    status_val[`SPMS_S_HOLDING_FULL_FLAG]      = holding_full_flag;
    status_val[`SPMS_S_BUSY]      = engine_busy_flag;
    status_val[`SPMS_S_MODE_FAULT_FLAG]      = mode_fault_flag;
    status_val[`SPMS_S_RATE_HIGH] = rate_select_high;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (rd_ev) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      case (paddr)
        `SPMS_CTRL_ADDR:   prdata[7:0] <= serial_control_reg;
        `SPMS_STATUS_ADDR: prdata[7:0] <= status_val;
        `SPMS_DATA_ADDR:   prdata[7:0] <= rx_buf;
        `SPMS_PINCFG_ADDR: prdata[0]   <= ss_gpio_out;
        default:           pslverr     <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fault_role_a: assert property (fault |=> !master_select_bit && !en && mode_fault_flag
    && transfer_done_flag) else $error("mode fault did not drop master role");
  fault_done_a: assert property (fault |=> ##1 !mosi_oe && !sck_oe)
    else $error("pins still driven after mode fault");
  disable_pins_a: assert property (!en |=> !mosi_oe && !miso_oe && !sck_oe)
    else $error("pins driven while disabled");
  slave_unsel_a: assert property (en && !master_select_bit && !select_ignore_bit && slave_select_pin_n |=>
    !miso_oe) else $error("unselected slave drives data out");
  slave_sel_a: assert property (en && !master_select_bit && !select_ignore_bit && !slave_select_pin_n |=>
    miso_oe && !sck_oe) else $error("selected slave pins wrong");
  idle_master_a: assert property (master_role && !select_ignore_bit && !active && !start && !fault
    |=> !mosi_oe) else $error("idle master drives data line");
  coll_drop_a: assert property (data_wr && holding_full_flag |=> write_collision_flag
    && $stable(tx_holding_reg)) else $error("collision write not dropped");
  hold_load_a: assert property (data_wr && !holding_full_flag |=> holding_full_flag
    ##1 (!holding_full_flag || $past(active || osr_full))) else $error("holding register stuck");
  done_end_a: assert property (xfer_end |=> transfer_done_flag && !active)
    else $error("end of byte did not set done flag");
  clk_stop_a: assert property (state == spms_pkg::SPMS_IDLE |=> sck_out == $past(clock_polarity_bit))
    else $error("serial clock not at idle level");
  busy_a: assert property (active |-> engine_busy_flag)
    else $error("busy flag low during transfer");

  master_byte_c: cover property (start ##[1:200] xfer_end);
  slave_byte_c:  cover property (!master_role && xfer_end);
  fault_c:       cover property (fault);
  coll_c:        cover property (data_wr && holding_full_flag);

endmodule // spms_top

// file: spms_cfg.svh
`ifndef SPMS_CFG_SVH
`define SPMS_CFG_SVH

// Register byte addresses
`define SPMS_CTRL_ADDR    8'h00
`define SPMS_STATUS_ADDR  8'h04
`define SPMS_DATA_ADDR    8'h08
`define SPMS_PINCFG_ADDR  8'h0c

// Control register fields
`define SPMS_C_IGNORE     7
`define SPMS_C_ENABLE     6
`define SPMS_C_ORDER      5
`define SPMS_C_MASTER     4
`define SPMS_C_CLOCK_POLARITY_BIT       3
`define SPMS_C_CLOCK_PHASE_BIT       2
`define SPMS_C_RATE_MID   1
`define SPMS_C_RATE_LOW   0
`define SPMS_CTRL_RST     8'h04

// Status register fields
`define SPMS_S_DONE       7
`define SPMS_S_WRITE_COLLISION_FLAG       6
`define SPMS_S_HOLDING_FULL_FLAG       5
`define SPMS_S_BUSY       4
`define SPMS_S_MODE_FAULT_FLAG       3
`define SPMS_S_RATE_HIGH  0

// Pin configuration: slave select used as a general output
`define SPMS_P_SS_GPIO    0

// Serial clock half periods, in source ticks
`define SPMS_HALF_DIV4    6'h02
`define SPMS_HALF_DIV8    6'h04
`define SPMS_HALF_DIV16   6'h08
`define SPMS_HALF_DIV32   6'h10
`define SPMS_HALF_DIV64   6'h20
`define SPMS_HALF_DIV2    6'h01
`define SPMS_HALF_OVF6    6'h03
`define SPMS_RATE_UART    3'h6
`define SPMS_RATE_TIMER   3'h7
`define SPMS_LAST_BIT     3'h7

`endif

// file: spms_pkg.sv
package spms_pkg;
  typedef enum logic {SPMS_IDLE, SPMS_XFER} spms_state_t;
endpackage

// file: spms_peer.sv
`timescale 1ns/1ps

module spms_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  logic bit_q = 1'b0;

  // Deselected line shows the inverse of the last bit, never a stale copy
  assign miso = cs_n ? ~bit_q : bit_q;

  always @(negedge cs_n) begin
    rx = tx;
    bit_q = lsb ? tx[0] : tx[7];
  end

  always @(sck) begin
    if (!cs_n && ((sck != clock_polarity_bit) ^ clock_phase_bit)) begin
      rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    end else if (!cs_n) begin
      bit_q = lsb ? rx[0] : rx[7];
    end
  end
endmodule // spms_peer

// file: spi_master_slave_port_test.sv
`timescale 1ns/1ps
`include "spms_cfg.svh"

module spi_master_slave_port_test;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        uov = 1'b0, tov = 1'b0, ss_n = 1'b1, cs_n = 1'b1, err, sck_q = 1'b0;
  logic        t_sck = 1'b0, t_mosi = 1'b0, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b1, lsb = 1'b0;
  logic        pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        peer_miso;
  logic [7:0]  paddr = 8'h00, peer_tx = 8'h00, peer_rx, got;
  logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'ha788dd92;
  int          n_fail = 0, tests_run = 0, cyc = 0, run = 0, gap = 0, act_n = 0, a0;
  wire         sck_w  = sck_oe ? sck_out : t_sck;
  wire         mosi_w = mosi_oe ? mosi_out : t_mosi;
  wire         miso_w = miso_oe ? miso_out : peer_miso;

  spms_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uart_baud_overflow(uov), .timer0_overflow(tov),
    .slave_select_pin_n(ss_n), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe));

  spms_peer u_peer (.sck(sck_w), .mosi(mosi_w), .cs_n(cs_n), .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit),
    .lsb(lsb), .tx(peer_tx), .miso(peer_miso), .rx(peer_rx));

  always #12.5 pclk = ~pclk;

  // Overflow sources, clock half-period monitor and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    uov <= cyc[0];
    tov <= (cyc % 3) == 0;
    sck_q <= sck_out;
    run <= (sck_out !== sck_q) ? 1 : run + 1;
    if (sck_out !== sck_q) gap <= run;
    if (sck_oe && mosi_oe) act_n <= act_n + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int half_of(input logic [2:0] c);
    return (c == 3'h5) ? 1 : (c == 3'h6) ? 6 : (c == 3'h7) ? 9 : 2 << c;
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic clr(input logic [7:0] m);
    apb(1'b1, `SPMS_STATUS_ADDR, {24'h0, m});
    apb(1'b0, `SPMS_STATUS_ADDR, 32'h0);
  endtask

  task automatic cfg(input logic ign, input logic mst, input logic [2:0] rate);
    apb(1'b1, `SPMS_STATUS_ADDR, {31'h0, rate[2]});
    apb(1'b1, `SPMS_CTRL_ADDR, {24'h0, ign, 1'b1, lsb, mst, clock_polarity_bit, clock_phase_bit, rate[1:0]});
    t_sck <= clock_polarity_bit;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, `SPMS_STATUS_ADDR, 32'h0);
      n++;
    end while (rd[`SPMS_S_DONE] !== 1'b1 && n < 300);
    chk(32'(rd[`SPMS_S_DONE]), 32'h1, "done flag");
  endtask

  task automatic mxfer(input logic [2:0] rate, input logic [7:0] mb);
    cfg(1'b0, 1'b1, rate);
    chk(32'({sck_oe, mosi_oe, miso_oe}), 32'h0, "idle master pins");
    cs_n <= 1'b0;
    a0 = act_n;
    apb(1'b1, `SPMS_DATA_ADDR, {24'h0, mb});
    wait_done();
    chk(32'(act_n > a0), 32'h1, "master drive");
    chk(32'(gap), 32'(half_of(rate)), "half bit");
    chk(32'(sck_out), 32'(clock_polarity_bit), "clock idle");
    chk(32'(peer_rx), 32'(mb), "peer byte");
    apb(1'b0, `SPMS_DATA_ADDR, 32'h0);
    chk(rd, 32'(peer_tx), "master byte");
    clr(8'h80);
    chk(32'(rd[`SPMS_S_DONE]), 32'h0, "done clear");
    cs_n <= 1'b1;
  endtask

  task automatic sbyte(input logic [7:0] m);
    for (int i = 7; i >= 0; i--) begin
      t_sck <= 1'b1;
      t_mosi <= m[i];
      repeat (4) @(posedge pclk);
      t_sck <= 1'b0;
      got[i] = miso_w;
      repeat (4) @(posedge pclk);
    end
    t_mosi <= ~m[0];
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({sck_oe, mosi_oe, miso_oe}), 32'h0, "disabled pins");
    apb(1'b0, `SPMS_CTRL_ADDR, 32'h0);
    chk(rd, 32'(`SPMS_CTRL_RST), "ctrl reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    // Every rate code, every clock mode, random order bit and data
    for (int c = 0; c < 8; c++) begin
      r = xs();
      {clock_polarity_bit, clock_phase_bit} <= c[1:0];
      lsb <= r[0];
      peer_tx <= r[15:8];
      @(posedge pclk);
      mxfer(3'(c), r[23:16]);
    end
    {clock_polarity_bit, clock_phase_bit, lsb} <= 3'b010;
    peer_tx <= 8'h3c;
    @(posedge pclk);
    cfg(1'b0, 1'b1, 3'h4);
    cs_n <= 1'b0;
    r = xs();
    apb(1'b1, `SPMS_DATA_ADDR, {24'h0, r[7:0]});
    apb(1'b1, `SPMS_DATA_ADDR, {24'h0, r[15:8]});
    apb(1'b0, `SPMS_STATUS_ADDR, 32'h0);
    chk(rd & 32'h70, 32'h30, "holding full busy");
    apb(1'b1, `SPMS_DATA_ADDR, {24'h0, r[23:16]});
    apb(1'b0, `SPMS_STATUS_ADDR, 32'h0);
    chk(rd & 32'h70, 32'h70, "collision");
    wait_done();
    clr(8'h80);
    wait_done();
    apb(1'b0, `SPMS_DATA_ADDR, 32'h0);
    chk(rd, {24'h0, r[7:0]}, "circular return");
    chk(32'(peer_rx), 32'(r[15:8]), "second byte");
    clr(8'hc0);
    chk(rd & 32'hd0, 32'h0, "flags clear idle");
    cs_n <= 1'b1;
    cfg(1'b0, 1'b1, 3'h0);
    ss_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'({sck_oe, mosi_oe}), 32'h0, "fault release");
    apb(1'b0, `SPMS_CTRL_ADDR, 32'h0);
    chk(rd & 32'h50, 32'h0, "fault ctrl");
    apb(1'b0, `SPMS_STATUS_ADDR, 32'h0);
    chk(rd & 32'h88, 32'h88, "fault flags");
    clr(8'h88);
    chk(rd & 32'h88, 32'h0, "disabled ignores select");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `SPMS_PINCFG_ADDR, 32'h1);
      cfg(k[0], 1'b1, 3'h0);
      apb(1'b1, `SPMS_PINCFG_ADDR, 32'(1 - k));
      repeat (4) @(posedge pclk);
      chk(32'(mosi_oe), 32'(k), "ignore pins");
      apb(1'b0, `SPMS_STATUS_ADDR, 32'h0);
      chk(rd & 32'h88, 32'h0, "select ignored");
      apb(1'b0, `SPMS_CTRL_ADDR, 32'h0);
      chk(rd & 32'h50, 32'h50, "still master");
    end
    ss_n <= 1'b1;
    apb(1'b1, `SPMS_PINCFG_ADDR, 32'h0);
    cfg(1'b0, 1'b0, 3'h0);
    r = xs();
    apb(1'b1, `SPMS_DATA_ADDR, {24'h0, r[7:0]});
    chk(32'({sck_oe, mosi_oe, miso_oe}), 32'h0, "slave unselected");
    ss_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'({sck_oe, mosi_oe, miso_oe}), 32'h1, "slave selected");
    for (int b = 0; b < 2; b++) begin
      sbyte(r[31:24]);
      chk(32'(got), 32'(r[7:0]), "slave sent");
      wait_done();
      apb(1'b0, `SPMS_DATA_ADDR, 32'h0);
      chk(rd, {24'h0, r[31:24]}, "slave got");
      clr(8'h80);
      r = xs();
      apb(1'b1, `SPMS_DATA_ADDR, {24'h0, r[7:0]});
    end
    close_out();
  end
endmodule // spi_master_slave_port_test
